// File: common/fps_pkg.sv
// Contract
// - program needs two unlocks then A0H
// - word load: one strobe pulse, up to 64
// - next word load starts within 30us
// - A6-A19 page stable, A0-A5 word
// - chip erase is six write cycles
// - sector erase ends with 30H at sector
// - caller erases sector before programming page; t_program programs page 12340H with no erase first
// - unlocks AAH@5555H, 55H@2AAAH on A0-A14
package fps_pkg;
  // ---------------------------------------------------------------
  // bus codes and timing
  // ---------------------------------------------------------------
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h05555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h02AAA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam int READY_BIT = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int UPPER_READY_BIT = 23;
  localparam int UPPER_SUSPEND_BIT = 22;
  localparam int SECTOR_LSB = 16;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_WORDS = 64;
  localparam int CLK_MHZ = 100;
  localparam int GAP_MAX_US = 30;
  // longest gap in clock cycles: the full 30us at CLK_MHZ, no margin
  localparam int GAP_CYCLES = GAP_MAX_US * CLK_MHZ;
  localparam int STROBE_CYCLES = 8; // 80 ns low pulse, slow parts safe
  localparam int SETUP_CYCLES = 2;
  localparam int READ_CYCLES = 20; // 200 ns access, slowest grade
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

  typedef enum logic [2:0] {
    FPS_OP_PROGRAM,
    FPS_OP_CHIP_ERASE,
    FPS_OP_SECTOR_ERASE,
    FPS_OP_SUSPEND,
    FPS_OP_RESUME,
    FPS_OP_STATUS
  } fps_op_e;

  // one request from the user side
  typedef struct packed {
    fps_op_e op;
    logic [19:0] addr;
    logic [6:0] count; // page words, 1..64
  } fps_req_s;

  // flash pins driven by the host
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [19:0] addr;
  } fps_pins_s;
endpackage : fps_pkg

// File: design/fps_host.sv
`timescale 1ns/1ps
`default_nettype none
module fps_host #(
  parameter int WORDS = 64,
  parameter int GAP = 3000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire fps_pkg::fps_req_s req,
  output logic req_ready,
  input wire logic [31:0] word_data,
  output logic word_take,
  output logic [5:0] word_index,
  output fps_pkg::fps_pins_s pins,
  output logic [31:0] data_out,
  output logic [31:0] data_oe_n,
  input wire logic [31:0] data_in,
  output logic [31:0] status,
  output logic status_valid
);
  import fps_pkg::*;

  // elaboration guard: at most one page of loads, gap must fit a cycle
  if (WORDS < 1 || WORDS > PAGE_WORDS || GAP < STROBE_CYCLES + SETUP_CYCLES) begin : g_bad_param
    $error("fps_host: bad parameter");
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FPS_IDLE, FPS_SETUP, FPS_LOW, FPS_HIGH, FPS_RSET, FPS_READ
  } fps_state_e;

  fps_state_e state, next_state;
  fps_req_s cur, next_cur;
  logic [2:0] step, next_step;
  logic [6:0] sent, next_sent;
  logic [15:0] cnt, next_cnt;
  fps_pins_s next_pins;
  logic [31:0] next_data_out, next_data_oe_n, next_status;
  logic next_req_ready, next_status_valid, next_word_take;
  logic [5:0] next_word_index;
  logic [19:0] cyc_addr;
  logic [7:0] cyc_data;
  logic last_cycle, is_load;

  // both lanes get the same command byte
  function automatic logic [31:0] lanes(input logic [7:0] b);
    lanes = {8'h00, b, 8'h00, b};
  endfunction : lanes

  // cycle table: steps 0..1 unlock, 2 command, 3..5 second half
  always_comb begin
    cyc_addr = UNLOCK_ADDR1;
    cyc_data = UNLOCK_DATA1;
    is_load = 1'b0;
    unique case (step)
      3'd1, 3'd4: begin
        cyc_addr = UNLOCK_ADDR2;
        cyc_data = UNLOCK_DATA2;
      end
      3'd2: begin
        unique case (cur.op)
          // program after two unlocks; caller erases sector first
          FPS_OP_PROGRAM: cyc_data = CMD_PROGRAM;
          FPS_OP_CHIP_ERASE, FPS_OP_SECTOR_ERASE: cyc_data = CMD_SETUP;
          FPS_OP_SUSPEND: cyc_data = CMD_SUSPEND;
          FPS_OP_RESUME: cyc_data = CMD_RESUME;
          default: cyc_data = CMD_READ_STATUS;
        endcase
      end
      3'd5: begin
        if (cur.op == FPS_OP_SECTOR_ERASE) begin
          cyc_addr = cur.addr;
          cyc_data = CMD_SECTOR_ERASE;
        end else begin
          cyc_data = CMD_CHIP_ERASE;
        end
      end
      3'd6: is_load = 1'b1;
      default: ;
    endcase
  end

  // loads stop at count, never past one page
  assign last_cycle = (step == 3'd2 && cur.op != FPS_OP_CHIP_ERASE &&
                       cur.op != FPS_OP_SECTOR_ERASE && cur.op != FPS_OP_PROGRAM) ||
                      (step == 3'd5) ||
                      (is_load && (sent + 7'd1 >= cur.count || sent + 7'd1 >= 7'(WORDS)));

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_step = step;
    next_sent = sent;
    next_cnt = cnt;
    next_pins = pins;
    next_data_out = data_out;
    next_data_oe_n = data_oe_n;
    next_status = status;
    next_req_ready = 1'b0;
    next_status_valid = 1'b0;
    next_word_take = 1'b0;
    next_word_index = word_index;
    unique case (state)
      FPS_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_cur = req;
          next_step = 3'd0;
          next_sent = 7'd0;
          next_req_ready = 1'b0;
          next_cnt = 16'(SETUP_CYCLES);
          next_state = FPS_SETUP;
        end
      end
      FPS_SETUP: begin
        next_pins.addr = is_load ?
          {cur.addr[19:PAGE_LSB], sent[5:0]} : cyc_addr;
        next_data_out = is_load ? word_data : lanes(cyc_data);
        next_data_oe_n = 32'h0000_0000;
        next_pins.oe_n = 1'b1;
        next_pins.ce_n = 1'b0;
        next_word_index = sent[5:0];
        if (cnt <= 16'd1) begin
          // we pulse with ce low, oe high
          next_pins.we_n = 1'b0;
          next_cnt = 16'(STROBE_CYCLES);
          next_state = FPS_LOW;
        end else begin
          next_cnt = cnt - 16'd1;
        end
      end
      FPS_LOW: begin
        if (cnt <= 16'd1) begin
          next_pins.we_n = 1'b1;
          next_word_take = is_load;
          next_cnt = 16'(SETUP_CYCLES);
          next_state = FPS_HIGH;
        end else begin
          next_cnt = cnt - 16'd1;
        end
      end
      FPS_HIGH: begin
        if (cnt <= 16'd1) begin
          next_pins.ce_n = 1'b1;
          next_data_oe_n = 32'hFFFF_FFFF;
          if (last_cycle) begin
            // silence lets the device start programming
            next_state = FPS_RSET;
            next_cnt = 16'(READ_CYCLES);
          end else begin
            if (is_load) begin
              next_sent = sent + 7'd1;
            end else begin
              next_step = step + 3'd1;
            end
            if (step == 3'd2 && cur.op == FPS_OP_PROGRAM) begin
              next_step = 3'd6;
            end
            next_cnt = 16'(SETUP_CYCLES);
            next_state = FPS_SETUP;
          end
        end else begin
          next_cnt = cnt - 16'd1;
        end
      end
      FPS_RSET: begin
        // device now in status mode; read it once
        next_pins.ce_n = 1'b0;
        next_pins.oe_n = 1'b0;
        if (cnt <= 16'd1) begin
          next_state = FPS_READ;
        end else begin
          next_cnt = cnt - 16'd1;
        end
      end
      FPS_READ: begin
        next_status = data_in;
        next_status_valid = 1'b1;
        next_pins.ce_n = 1'b1;
        next_pins.oe_n = 1'b1;
        next_state = FPS_IDLE;
      end
      default: next_state = FPS_IDLE;
    endcase
  end

  // gap between word loads stays well under 30us
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= FPS_IDLE;
      cur <= '0;
      step <= 3'd0;
      sent <= 7'd0;
      cnt <= 16'd0;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000};
      data_out <= 32'h0000_0000;
      data_oe_n <= 32'hFFFF_FFFF;
      status <= 32'h0000_0000;
      req_ready <= 1'b0;
      status_valid <= 1'b0;
      word_take <= 1'b0;
      word_index <= 6'h00;
    end else begin
      state <= next_state;
      cur <= next_cur;
      step <= next_step;
      sent <= next_sent;
      cnt <= next_cnt;
      pins <= next_pins;
      data_out <= next_data_out;
      data_oe_n <= next_data_oe_n;
      status <= next_status;
      req_ready <= next_req_ready;
      status_valid <= next_status_valid;
      word_take <= next_word_take;
      word_index <= next_word_index;
    end
  end
endmodule : fps_host
`default_nettype wire

// File: test/fps_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module fps_host_props #(parameter int WORDS = 64, parameter int GAP = 3000) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic word_take,
  input wire logic [5:0] word_index,
  input wire fps_pkg::fps_pins_s pins,
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe_n,
  input wire logic status_valid
);
  import fps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_low; !pins.we_n [*8]; endsequence
  sequence s_aa; !pins.we_n && data_out[7:0] == 8'hAA; endsequence
  property p_strobe; $fell(pins.we_n) |-> s_low ##1 pins.we_n; endproperty
  property p_sel; !pins.we_n |-> !pins.ce_n && pins.oe_n; endproperty
  property p_drive; !pins.we_n |-> data_oe_n == '0; endproperty
  property p_hold; !pins.we_n && !$past(pins.we_n) |-> $stable({pins.addr, data_out}); endproperty
  property p_take; word_take |-> $rose(pins.we_n) && pins.addr[5:0] == word_index; endproperty
  property p_read; !pins.oe_n |-> &data_oe_n; endproperty
  property p_busy; req_valid && req_ready |=> !req_ready; endproperty
  property p_first; req_valid && req_ready |-> ##[1:8] s_aa; endproperty
  // after each strobe rise the next strobe or the status read follows well inside 30us
  property p_gap;
    $rose(pins.we_n) |-> ##[1:1000] ($fell(pins.we_n) || $fell(pins.oe_n));
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width");
  a_sel: assert property (p_sel) else $error("strobe select");
  a_drive: assert property (p_drive) else $error("bus not driven");
  a_hold: assert property (p_hold) else $error("address moved");
  a_take: assert property (p_take) else $error("load index");
  a_read: assert property (p_read) else $error("bus clash");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_first: assert property (p_first) else $error("no unlock");
  a_gap: assert property (p_gap) else $error("load gap too long");
endmodule : fps_host_props
bind fps_host fps_host_props #(.WORDS(WORDS), .GAP(GAP)) u_props (.clk(clk), .rstn(rstn),
  .req_valid(req_valid), .req_ready(req_ready), .word_take(word_take), .word_index(word_index),
  .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n), .status_valid(status_valid));
`default_nettype wire

// File: test/fps_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model #(parameter int BUSY = 300) (
  input wire logic clk,
  input wire fps_pkg::fps_pins_s pins,
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe_n,
  output logic [31:0] data_in,
  output logic [3:0] sector,
  output logic [63:0] filled,
  output logic [31:0] last_word,
  output int loads
);
  import fps_pkg::*;
  logic weq = 1, setup = 0, load = 0, erase = 0, susp = 0;
  logic [7:0] d1, d2, d;
  logic [14:0] a1, a2;
  logic [19:0] al;
  logic [31:0] st;
  logic unl;
  int cnt = 0;
  // a command counts only when both lanes are driven alike
  assign d = (data_oe_n[7:0] == 8'h00 && data_oe_n[23:16] == 8'h00 &&
              data_out[23:16] == data_out[7:0]) ? data_out[7:0] : 8'hFF;
  // unlock pair on low address bits
  assign unl = {d2, a2, d1, a1} == {8'hAA, 15'h5555, 8'h55, 15'h2AAA};
  assign st = {2{8'h00, cnt == 0 || susp, susp, 6'h00}};
  // reads give status; released bus shows the inverse, never a stale value
  assign data_in = (!pins.ce_n && !pins.oe_n) ? st : ~st;
  initial sector = '0;
  initial loads = 0;
  initial filled = '0;
  // decode on strobe edges, busy time counts down unless suspended
  always @(posedge clk) begin
    weq <= pins.we_n;
    if (cnt != 0 && !susp) cnt <= cnt - 1;
    if (!pins.oe_n) load <= 0;
    if (!pins.we_n && weq) al <= pins.addr;
    if (pins.we_n && !weq) begin
      {d2, d1, a2, a1} <= {d1, d, a1, al[14:0]};
      // each load reopens the window, one program pass
      // words left out of filled keep the erased value
      if (load) begin
        loads <= loads + 1;
        filled[al[5:0]] <= 1'b1;
        last_word <= data_out;
        cnt <= BUSY;
        erase <= 0;
      end else if (unl && d == CMD_RESUME) begin
        susp <= 0;
      end else if (unl && !susp) begin
        // program when idle, suspend in erase
        if (d == CMD_PROGRAM && cnt == 0) begin
          load <= 1;
          filled <= '0;
        end
        if (d == CMD_SUSPEND && erase && cnt != 0) susp <= 1;
        if (d == CMD_SETUP) setup <= 1;
        if (setup && (d == CMD_CHIP_ERASE || d == CMD_SECTOR_ERASE)) begin
          cnt <= BUSY;
          erase <= 1;
          sector <= al[19:16];
          setup <= 0;
        end
      end
    end
  end
endmodule : fps_flash_model
`default_nettype wire

// File: test/test_flash_program_erase_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_sequencer;
  import fps_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic req_valid = 0;
  fps_req_s req = '0;
  logic [31:0] word_data = '0;
  logic req_ready, word_take, status_valid;
  logic [5:0] word_index;
  fps_pins_s pins;
  logic [31:0] data_out, data_oe_n, data_in, status, s, last_word;
  logic [63:0] filled;
  logic [3:0] sector;
  int loads, takes = 0, cyc = 0, n_fail = 0, n_checks = 0;
  always #5 clk = ~clk;
  fps_host #(.WORDS(64), .GAP(3000)) dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .word_data(word_data), .word_take(word_take),
    .word_index(word_index), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in), .status(status), .status_valid(status_valid));
  fps_flash_model #(.BUSY(300)) mdl (.clk(clk), .pins(pins), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in), .sector(sector), .filled(filled),
    .last_word(last_word), .loads(loads));
  // page word follows its index
  always @(negedge clk) word_data <= {10'h000, word_index, 10'h000, word_index};
  // count loads and cut a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (word_take === 1'b1) takes <= takes + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] st(input logic r, input logic p);
    return {2{8'h00, r, p, 6'h00}};
  endfunction : st
  // request held until taken, then wait for its status
  task automatic op(input fps_op_e o, input logic [19:0] a, input logic [6:0] n);
    @(negedge clk);
    req = '{op: o, addr: a, count: n};
    req_valid = 1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 0;
    while (status_valid !== 1'b1) @(negedge clk);
    s = status;
  endtask : op
  task automatic poll();
    s = '0;
    for (int k = 0; k < 20 && s[7] !== 1'b1; k++) op(FPS_OP_STATUS, 20'h0, 7'h1);
  endtask : poll
  task automatic t_idle();
    op(FPS_OP_SUSPEND, 20'h0, 7'h1);
    check(s, st(1, 0));
    op(FPS_OP_RESUME, 20'h0, 7'h1);
    check(s, st(1, 0));
  endtask : t_idle
  task automatic t_program();
    op(FPS_OP_PROGRAM, 20'h12340, 7'h40);
    check(s, st(0, 0));
    check(32'(takes), 32'h40);
    check(32'(loads), 32'h40);
    check(filled[31:0], 32'hFFFF_FFFF);
    check(filled[63:32], 32'hFFFF_FFFF);
    check(last_word, {2{10'h000, 6'h3F}});
    poll();
    check(s, st(1, 0));
  endtask : t_program
  task automatic t_chip();
    op(FPS_OP_CHIP_ERASE, 20'h0, 7'h1);
    check(s, st(0, 0));
    op(FPS_OP_SUSPEND, 20'h0, 7'h1);
    check(s, st(1, 1));
    op(FPS_OP_RESUME, 20'h0, 7'h1);
    check(s, st(0, 0));
    poll();
    check(s, st(1, 0));
  endtask : t_chip
  task automatic t_sector();
    op(FPS_OP_SECTOR_ERASE, 20'hF1234, 7'h1);
    check({28'h0, sector}, 32'hF);
    check(s, st(0, 0));
    poll();
    check(s, st(1, 0));
  endtask : t_sector
  // short page into the sector just erased; the rest must stay erased
  task automatic t_partial();
    op(FPS_OP_PROGRAM, 20'hF1240, 7'h03);
    check(32'(takes), 32'h43);
    check(filled[31:0], 32'h0000_0007);
    check(filled[63:32], 32'h0000_0000);
    check(last_word, {2{10'h000, 6'h02}});
    poll();
    check(s, st(1, 0));
  endtask : t_partial
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(negedge clk);
    check({29'h0, pins.ce_n, pins.we_n, pins.oe_n}, 32'h7);
    rstn = 1;
    t_idle();
    t_program();
    t_chip();
    t_sector();
    t_partial();
    conclude();
  end
endmodule : test_flash_program_erase_sequencer
`default_nettype wire
